// file: rtl/hpp_consts.svh
`ifndef HPP_CONSTS_SVH
`define HPP_CONSTS_SVH

// AXI4-Lite register byte offsets.
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_IRQ_CLR 8'h08
`define OFS_IRQ_EN 8'h0c
`define OFS_ALARM 8'h10
`define OFS_LAST_ADDR 8'h14
`define OFS_LAST_WDATA 8'h18
`define OFS_RDATA 8'h1c

// Control register fields.
`define CTRL_MUX_BIT 0
`define CTRL_HWMODE_BIT 1
`define CTRL_STROBE_BIT 2

// Interrupt status fields.
`define ST_NOSIG_BIT 0
`define ST_ONES_BIT 1
`define ST_WR_BIT 2
`define ST_RD_BIT 3
`define ST_W 4

// Reset values.
`define CTRL_RST 32'h0000_0000
`define IRQEN_RST 4'h0

// Wait inserted on a write that directly follows another cycle, in ns and in cycles at 200 MHz.
`define WAIT_NS 20
`define CLK_MHZ 200
`define WAIT_CYC ((`WAIT_NS * `CLK_MHZ + 999) / 1000)

`endif

// file: rtl/hpp_pkg.sv
package hpp_pkg;
	// Host pin group: inputs seen from the host side.
	typedef struct packed {
		logic sel_n;
		logic rd_n;
		logic wr_n;
		logic ale;
		logic addr_valid_strobe_n;
		logic data_phase_strobe_n;
		logic rw;
		logic [4:0] addr;
		logic [7:0] data;
	} host_in_s;

	typedef enum logic [1:0] {
		BUS_SEP,
		BUS_STROBE
	} bus_style_e;
endpackage : hpp_pkg

// file: rtl/hpp_alarm_irq.sv
`timescale 1ns/100ps
`include "hpp_consts.svh"

// Alarm edge detection and sticky interrupt status.
module hpp_alarm_irq
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic [1:0] alarm_i,
	input wire logic [1:0] evt_i,
	input wire logic [`ST_W-1:0] clr_i,
	input wire logic [`ST_W-1:0] en_i,
	output logic [`ST_W-1:0] status_o,
	output logic irq_o
);
	logic [1:0] alarm_q;
	logic [`ST_W-1:0] set_w;

	// Any change of an alarm level is an event.
	assign set_w = {evt_i, alarm_i ^ alarm_q};

	// Alarm history.
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			alarm_q <= 2'h0;
		else
			alarm_q <= alarm_i;
	end

	// Set beats clear so a change landing on a clear is kept.
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			status_o <= '0;
		else
			status_o <= (status_o & ~clr_i) | set_w; // see [RULE_08]
	end

	// Level output falls back once nothing enabled is pending.
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(((status_o & ~clr_i) | set_w) & en_i); // see [RULE_15]
	end
endmodule : hpp_alarm_irq

// file: rtl/host_parallel_bus_port.sv
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "hpp_consts.svh"
// Overview of operation
// [RULE_01] Host accesses are accepted only while the low-active select is low.
// [RULE_02] In hardware mode the select pin becomes the jitter path select.
// [RULE_03] Non-multiplexed: eight pins are a pure bidirectional data port.
// [RULE_04] Multiplexed: eight pins carry low address then data.
// [RULE_05] In hardware mode the data pins are per-channel loopback controls.
// [RULE_06] Host marks the data phase with a low data strobe.
// [RULE_07] Interrupt output is low-active, open drain and maskable.
// [RULE_08] Enabled alarm status changes pull the interrupt low.
// [RULE_09] Host treats the interrupt as level sensitive.
// [RULE_10] Host drives read enable low to have the device drive data.
// [RULE_11] Multiplexed address is captured at the latch enable falling edge.
// [RULE_12] Acknowledge goes low for valid read data or accepted write data.
// [RULE_13] Wait states only when a write directly follows another cycle.
// [RULE_14] Host qualifies the address phase with a low address strobe.
// [RULE_15] Interrupt releases once no enabled change is pending.
// [RULE_16] Data pins float unless selected and reading.

module host_parallel_bus_port
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire hpp_pkg::host_in_s host_i,
	input wire logic no_signal_alarm_i,
	input wire logic all_ones_alarm_i,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [7:0] data_o,
	output logic data_oe_o,
	output logic ack_n_o,
	output logic ack_oe_o,
	output logic irq_n_o,
	output logic irq_oe_o,
	output logic jitter_path_select_o,
	output logic [7:0] channel_test_return_o
);
	import hpp_pkg::*;

	// ****************************************************************
	// Registers and host-side state
	// ****************************************************************
	logic [31:0] ctrl_q;
	logic [`ST_W-1:0] irq_en_q;
	logic [`ST_W-1:0] irq_clr_d;
	logic [`ST_W-1:0] status_w;
	logic irq_w;
	logic [7:0] addr_q;
	logic [7:0] wdata_q;
	logic [7:0] rdata_q;
	logic ale_q;
	logic access_q;
	logic was_access_q;
	logic [3:0] wait_q;
	logic wr_evt_d;
	logic rd_evt_d;
	logic [31:0] aw_q;
	logic [31:0] wd_q;
	logic [3:0] ws_q;
	logic aw_have_q;
	logic w_have_q;

	wire logic mux_w = ctrl_q[`CTRL_MUX_BIT];
	wire logic hw_w = ctrl_q[`CTRL_HWMODE_BIT];
	wire logic strobe_w = ctrl_q[`CTRL_STROBE_BIT];

	// A host access needs select low and host mode.
	wire logic sel_w = !host_i.sel_n && !hw_w; // see [RULE_01]
	// Read request: read enable in separate style, direction bit with strobe otherwise.
	wire logic rd_w = sel_w && (strobe_w ? (!host_i.data_phase_strobe_n && host_i.rw)
		: !host_i.rd_n); // see [RULE_06] see [RULE_10]
	wire logic wr_w = sel_w && (strobe_w ? (!host_i.data_phase_strobe_n && !host_i.rw)
		: !host_i.wr_n);
	wire logic act_w = rd_w || wr_w;
	// Address in use: latched byte when multiplexed, pins otherwise.
	wire logic [7:0] eff_addr_w = mux_w ? addr_q : {3'h0, host_i.addr}; // see [RULE_03]

	// Return the register value at a host or bus byte offset.
	function automatic logic [31:0] reg_read(input logic [7:0] a);
		unique case (a)
			`OFS_CTRL: reg_read = ctrl_q;
			`OFS_STATUS: reg_read = {28'h0, status_w};
			`OFS_IRQ_EN: reg_read = {28'h0, irq_en_q};
			`OFS_ALARM: reg_read = {30'h0, all_ones_alarm_i, no_signal_alarm_i};
			`OFS_LAST_ADDR: reg_read = {24'h0, addr_q};
			`OFS_LAST_WDATA: reg_read = {24'h0, wdata_q};
			`OFS_RDATA: reg_read = {24'h0, rdata_q};
			default: reg_read = 32'h0;
		endcase
	endfunction : reg_read

	// ****************************************************************
	// Parallel host port
	// ****************************************************************

	// Address latch on the falling edge of the latch enable; strobe style latches
	// while the address strobe is low.
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			ale_q <= 1'b0;
			addr_q <= 8'h00;
		end
		else
		begin
			ale_q <= host_i.ale;
			if (sel_w && mux_w && ale_q && !host_i.ale && !strobe_w)
				addr_q <= host_i.data; // see [RULE_11] see [RULE_04]
			else if (sel_w && mux_w && strobe_w && !host_i.addr_valid_strobe_n)
				addr_q <= host_i.data; // see [RULE_14]
		end
	end

	// Access tracking and write wait states; only a write that follows straight on
	// from an earlier cycle is held off, a lone cycle is answered at once.
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			access_q <= 1'b0;
			was_access_q <= 1'b0;
			wait_q <= 4'h0;
		end
		else
		begin
			access_q <= act_w;
			if (act_w && !access_q)
			begin
				was_access_q <= 1'b1;
				wait_q <= (wr_w && was_access_q) ? 4'(`WAIT_CYC) : 4'h0; // see [RULE_13]
			end
			else if (wait_q != 4'h0)
				wait_q <= wait_q - 4'h1;
			if (!sel_w && !act_w)
				was_access_q <= 1'b0;
		end
	end

	// Acknowledge driven in strobe style while selected, low during an access once any wait has run out; floats otherwise.
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			ack_n_o <= 1'b1;
			ack_oe_o <= 1'b0;
		end
		else
		begin
			ack_n_o <= !(strobe_w && access_q && act_w && wait_q == 4'h0); // see [RULE_12]
			ack_oe_o <= strobe_w && sel_w;
		end
	end

	// Host write capture and read data; pins float outside a selected read.
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			wdata_q <= 8'h00;
			rdata_q <= 8'h00;
			data_o <= 8'h00;
			data_oe_o <= 1'b0;
		end
		else
		begin
			if (wr_w && !access_q)
				wdata_q <= host_i.data; // see [RULE_03]
			if (rd_w)
				rdata_q <= reg_read(eff_addr_w)[7:0];
			data_o <= reg_read(eff_addr_w)[7:0];
			data_oe_o <= rd_w; // see [RULE_16]
		end
	end

	// Hardware mode pin reuse.
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			jitter_path_select_o <= 1'b0;
			channel_test_return_o <= 8'h00;
		end
		else if (hw_w)
		begin
			jitter_path_select_o <= host_i.sel_n; // see [RULE_02]
			channel_test_return_o <= host_i.data; // see [RULE_05]
		end
	end

	// ****************************************************************
	// Interrupt
	// ****************************************************************
	assign wr_evt_d = wr_w && !access_q;
	assign rd_evt_d = rd_w && !access_q;

	hpp_alarm_irq u_irq
	(
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.alarm_i({all_ones_alarm_i, no_signal_alarm_i}),
		.evt_i({rd_evt_d, wr_evt_d}),
		.clr_i(irq_clr_d),
		.en_i(irq_en_q),
		.status_o(status_w),
		.irq_o(irq_w)
	);

	// Open drain: pull low only when asserting; the host must sample it as a level.
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			irq_n_o <= 1'b1;
			irq_oe_o <= 1'b0;
		end
		else
		begin
			irq_n_o <= 1'b0; // see [RULE_07]
			irq_oe_o <= irq_w; // see [RULE_09]
		end
	end

	// ****************************************************************
	// AXI4-Lite slave
	// ****************************************************************
	wire logic wr_go_w = aw_have_q && w_have_q && !s_axi_bvalid;

	// Write address and data accepted in either order.
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_q <= 32'h0;
			wd_q <= 32'h0;
			ws_q <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_q <= 1'b1;
				aw_q <= s_axi_awaddr;
			end
			else if (wr_go_w)
				aw_have_q <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_q <= 1'b1;
				wd_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end
			else if (wr_go_w)
				w_have_q <= 1'b0;
		end
	end

	assign s_axi_awready = !aw_have_q && !sys_rst_i;
	assign s_axi_wready = !w_have_q && !sys_rst_i;
	assign irq_clr_d = (wr_go_w && aw_q[7:0] == `OFS_IRQ_CLR && ws_q[0]) ? wd_q[`ST_W-1:0]
		: '0;

	// Register writes and write response; unmapped offsets answer SLVERR.
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			ctrl_q <= `CTRL_RST;
			irq_en_q <= `IRQEN_RST;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end
		else
		begin
			if (wr_go_w)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'b00;
				unique case (aw_q[7:0])
					`OFS_CTRL: if (ws_q[0]) ctrl_q[7:0] <= wd_q[7:0];
					`OFS_IRQ_EN: if (ws_q[0]) irq_en_q <= wd_q[`ST_W-1:0];
					`OFS_IRQ_CLR: ;
					default: s_axi_bresp <= 2'b10;
				endcase
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Read channel: one read at a time.
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'b00;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= reg_read(s_axi_araddr[7:0]);
				s_axi_rresp <= (s_axi_araddr[7:0] > `OFS_RDATA || s_axi_araddr[1:0] != 2'h0
					|| s_axi_araddr[7:0] == `OFS_IRQ_CLR) ? 2'b10 : 2'b00;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	AST_SEL_GATES_DATA: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		data_oe_o |-> $past(sel_w)) else $error("Data driven without select."); // see [RULE_01]
	AST_HW_JSEL: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		$past(hw_w) |-> jitter_path_select_o == $past(host_i.sel_n))
		else $error("Jitter select not following pin."); // see [RULE_02]
	AST_HW_LOOP: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		$past(hw_w) |-> channel_test_return_o == $past(host_i.data))
		else $error("Loopback pins not followed."); // see [RULE_05]
	AST_IRQ_OD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		irq_oe_o |-> !irq_n_o) else $error("Interrupt driven high."); // see [RULE_07]
	AST_IRQ_ALARM: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(irq_en_q[`ST_NOSIG_BIT] && $changed(no_signal_alarm_i)) |=> ##1 irq_oe_o)
		else $error("Alarm change did not interrupt."); // see [RULE_08]
	AST_IRQ_RELEASE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		((status_w & irq_en_q) == '0) ##1 ((status_w & irq_en_q) == '0) |=> !irq_oe_o)
		else $error("Interrupt held with nothing pending."); // see [RULE_15]
	AST_ALE_CAPTURE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(sel_w && mux_w && !strobe_w && ale_q && !host_i.ale) |=> addr_q == $past(host_i.data))
		else $error("Address not latched."); // see [RULE_11]
	AST_DATA_FLOAT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!$past(rd_w) |-> !data_oe_o) else $error("Data driven outside read."); // see [RULE_16]
	AST_WAIT_ONLY_WR: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(act_w && !access_q && !wr_w) |=> wait_q == 4'h0)
		else $error("Wait inserted on read."); // see [RULE_13]
endmodule : host_parallel_bus_port

// file: test/host_model.sv
`timescale 1ns/100ps
// ****************************************
// Host processor on the parallel port
// ****************************************
module host_model
(
	input wire logic mclk_i,
	input wire logic [7:0] data_i,
	input wire logic data_oe_i,
	input wire logic ack_i,
	output hpp_pkg::host_in_s host_o
);
	import hpp_pkg::*;

	// Idle bus: no select, every strobe high, latch enable low, pins low.
	initial host_o = 20'hee000;

	// Drives select and data pins as plain levels, for use as mode straps.
	task automatic pins(input logic sel_n, input logic [7:0] d);
		@(posedge mclk_i);
		host_o.sel_n <= sel_n;
		host_o.data <= d;
	endtask : pins

	// One host cycle. The host waits only a bounded time, so n is 12 when no answer came.
	// The data pins show the inverse of the last value once released, never a stale copy.
	task automatic access(input logic wr, stb, mux, sel, keep, input logic [7:0] a,
		inout logic [7:0] d, output int n);
		@(posedge mclk_i);
		host_o.sel_n <= ~sel;
		host_o.addr <= mux ? ~a[4:0] : a[4:0];
		host_o.data <= mux ? a : (wr ? d : ~host_o.data);
		host_o.ale <= mux & ~stb;
		host_o.addr_valid_strobe_n <= ~stb;
		// The address stays on the pins through the falling latch enable edge.
		if (mux)
		begin
			@(posedge mclk_i);
			host_o.ale <= 1'b0;
		end
		@(posedge mclk_i);
		if (mux)
			host_o.data <= wr ? d : ~a;
		host_o.rw <= ~wr;
		host_o.data_phase_strobe_n <= ~stb;
		host_o.rd_n <= wr | stb;
		host_o.wr_n <= ~wr | stb;
		n = 0;
		do
		begin
			@(posedge mclk_i);
			n++;
		end while (n < 12 && !(stb ? ack_i === 1'b0 : (wr ? n == 3 : data_oe_i === 1'b1)));
		if (!wr)
			d = data_i;
		host_o.rd_n <= 1'b1;
		host_o.wr_n <= 1'b1;
		host_o.data_phase_strobe_n <= 1'b1;
		host_o.addr_valid_strobe_n <= 1'b1;
		host_o.sel_n <= ~(sel & keep);
		host_o.data <= ~host_o.data;
		@(posedge mclk_i);
	endtask : access
endmodule : host_model

// file: test/tb_top.sv
`timescale 1ns/100ps
`include "hpp_consts.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module tb_top;
	import hpp_pkg::*;
	// ****************************************
	// Signals, clock and instances
	// ****************************************
	logic mclk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	host_in_s host;
	logic nosig = 1'b0;
	logic ones = 1'b0;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, data_oe, ack_n, ack_oe, irq_n, irq_oe, jsel;
	logic [1:0] bresp, rresp;
	logic [7:0] data_o, ctr, d;
	int n_errors = 0;
	int n_compared = 0;
	int n, n2, nr;
	// Open-drain lines idle high through their pull-ups.
	wire irq_line = irq_oe ? irq_n : 1'b1;
	wire ack_line = ack_oe ? ack_n : 1'b1;

	// Free-running 200 MHz clock.
	always #2.5 mclk_i = ~mclk_i;

	host_parallel_bus_port i_host_parallel_bus_port (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
		.host_i(host), .no_signal_alarm_i(nosig), .all_ones_alarm_i(ones),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.data_o(data_o), .data_oe_o(data_oe), .ack_n_o(ack_n), .ack_oe_o(ack_oe),
		.irq_n_o(irq_n), .irq_oe_o(irq_oe), .jitter_path_select_o(jsel),
		.channel_test_return_o(ctr));

	host_model i_host_model (.mclk_i(mclk_i), .data_i(data_o), .data_oe_i(data_oe),
		.ack_i(ack_line), .host_o(host));

	// ****************************************
	// Bus tasks and closing report
	// ****************************************
	task automatic print_verdict();
		$display("compared %0d, wrong %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict

	// Address and data are offered together; each is dropped once taken.
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] dv, input logic [1:0] er);
		int k;
		k = 0;
		@(posedge mclk_i);
		awaddr <= a;
		wdata <= dv;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge mclk_i);
			k++;
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && k < 50);
		bready <= 1'b0;
		`CHK(bresp, er)
		if (k >= 50)
		begin
			n_errors++;
			print_verdict();
		end
	endtask : axi_wr

	task automatic axi_rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
		int k;
		k = 0;
		@(posedge mclk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge mclk_i);
			k++;
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && k < 50);
		rready <= 1'b0;
		`CHK(rdata, e)
		`CHK(rresp, er)
		if (k >= 50)
		begin
			n_errors++;
			print_verdict();
		end
	endtask : axi_rd

	// ****************************************
	// Test sequence
	// ****************************************
	initial
	begin
		repeat (5) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		`CHK(data_oe, 1'b0)
		`CHK(irq_line, 1'b1)
		axi_rd(`OFS_CTRL, `CTRL_RST, 2'b00);
		axi_rd(`OFS_IRQ_EN, 32'h0, 2'b00);
		axi_rd(32'h20, 32'h0, 2'b10);
		axi_wr(32'h24, 32'h1, 2'b10);
		axi_wr(`OFS_IRQ_EN, 32'h5, 2'b00);
		$display("test registers done");
		i_host_model.access(0, 0, 0, 1, 0, 8'h0c, d, n);
		`CHK(d, 8'h05)
		@(negedge mclk_i);
		`CHK(data_oe, 1'b0)
		axi_rd(`OFS_RDATA, 32'h5, 2'b00);
		i_host_model.access(0, 0, 0, 0, 0, 8'h0c, d, n);
		`CHK(n, 12)
		d = 8'ha5;
		i_host_model.access(1, 0, 0, 1, 0, 8'h18, d, n);
		axi_rd(`OFS_LAST_WDATA, 32'ha5, 2'b00);
		// Only the multiplexed latch records an address, so it still reads its reset value.
		axi_rd(`OFS_LAST_ADDR, 32'h0, 2'b00);
		axi_wr(`OFS_CTRL, 32'h1, 2'b00);
		i_host_model.access(0, 0, 1, 1, 0, 8'h0c, d, n);
		`CHK(d, 8'h05)
		axi_rd(`OFS_LAST_ADDR, 32'h0c, 2'b00);
		$display("test separate strobes done");
		axi_wr(`OFS_CTRL, 32'h4, 2'b00);
		i_host_model.access(0, 1, 0, 1, 0, 8'h0c, d, nr);
		`CHK(d, 8'h05)
		i_host_model.access(1, 1, 0, 1, 1, 8'h14, d, n);
		i_host_model.access(1, 1, 0, 1, 0, 8'h14, d, n2);
		`CHK(n, nr)
		`CHK(n2, n + `WAIT_CYC)
		`CHK(n2 < 12, 1'b1)
		$display("test data strobe done");
		axi_wr(`OFS_CTRL, 32'h2, 2'b00);
		for (int i = 0; i < 2; i++)
		begin
			i_host_model.pins(i[0], i[0] ? 8'ha5 : 8'h5a);
			repeat (3) @(negedge mclk_i);
			`CHK(jsel, i[0])
			`CHK(ctr, i[0] ? 8'ha5 : 8'h5a)
		end
		i_host_model.access(0, 0, 0, 1, 0, 8'h0c, d, n);
		`CHK(n, 12)
		$display("test hardware mode done");
		axi_wr(`OFS_CTRL, 32'h0, 2'b00);
		axi_wr(`OFS_IRQ_CLR, 32'hf, 2'b00);
		axi_wr(`OFS_IRQ_EN, 32'h3, 2'b00);
		repeat (2) @(negedge mclk_i);
		`CHK(irq_line, 1'b1)
		@(posedge mclk_i);
		nosig <= 1'b1;
		repeat (3) @(negedge mclk_i);
		`CHK(irq_line, 1'b0)
		axi_rd(`OFS_STATUS, 32'h1, 2'b00);
		axi_rd(`OFS_ALARM, 32'h1, 2'b00);
		axi_wr(`OFS_IRQ_CLR, 32'h1, 2'b00);
		repeat (2) @(negedge mclk_i);
		`CHK(irq_line, 1'b1)
		axi_wr(`OFS_IRQ_EN, 32'h0, 2'b00);
		@(posedge mclk_i);
		ones <= 1'b1;
		repeat (3) @(negedge mclk_i);
		`CHK(irq_line, 1'b1)
		axi_rd(`OFS_STATUS, 32'h2, 2'b00);
		axi_wr(`OFS_IRQ_EN, 32'h2, 2'b00);
		repeat (2) @(negedge mclk_i);
		`CHK(irq_line, 1'b0)
		axi_wr(`OFS_IRQ_CLR, 32'h2, 2'b00);
		repeat (2) @(negedge mclk_i);
		`CHK(irq_line, 1'b1)
		$display("test interrupt done");
		print_verdict();
	end
endmodule : tb_top
